// ---- rtl/hbp_steering.sv ----
// half-bridge drive steering, dead-time and enable sequencing
`timescale 1ns/1ps
// Notes on behaviour
// - each drive output cycles once per two oscillator ticks
// - high and low pulses alternate, never overlapping, never repeated
// - sync slower than own period is ignored; internal timing continues
// - a qualifying sync rising edge starts a new oscillator period
// - on-time capped at half cycle minus lead and trail dead-times and one clock
// - without control current primaries run at maximum duty
// - rectifier B on, A off during whole high-side pulse
// - rectifier A on, B off during whole low-side pulse
// - both rectifiers on from the end of each trail dead-time until the next lead
// - rectifier A inverts high side, B inverts low side, plus dead-times
// - lead and trail dead-times programmable above fixed floors
// - no extra fixed dead-time is added beyond the floors
// - undervoltage or hiccup forces both rectifiers low
// - soft-start held low keeps both rectifiers high while drives are enabled
// - over-temperature enters standby, outputs and regulators off
// - thermal standby resets soft-start, restarts after release
// - bias regulator enabled only above start undervoltage level
// - reference enabled only after bias supply regulates
// - drives enabled when regulators ready, line sense high and run bit set
// - start-up regulator off once bias is raised externally
// - lead dead-time before each primary pulse, trail after it
module hbp_steering (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic oscTick,
	input wire logic freqSetInput,
	input wire logic pwmEnd,
	input wire logic controlCurrent,
	input wire logic restartTimerInput,
	input wire logic biasExternal,
	input wire hbp_pkg::hbp_status_t stat,
	input wire logic [7:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	output hbp_pkg::hbp_drive_t drive,
	output logic biasRegEnable,
	output logic refEnable,
	output logic startupRegEnable,
	output logic softStartDischarge
);
	import hbp_pkg::*;

	logic [31:0] ctrl;
	logic [31:0] dead;
	logic [PER_W-1:0] period;
	logic [PER_W-1:0] oscCount;
	logic [2:0] syncPipe;
	logic syncLevel;
	logic [PER_W-1:0] syncGap;
	logic [PER_W-1:0] tickSpan;
	logic [PER_W-1:0] spanEff;
	logic [PER_W-1:0] guardCyc;
	logic syncEdge;
	logic tick;
	logic phaseHigh;
	logic [DT_W:0] dtCount;
	hbp_state_t state;
	logic standby;
	logic outEnable;
	logic ackPending;
	logic [DT_W:0] leadCyc;
	logic [DT_W:0] trailCyc;
	logic [PER_W-1:0] halfLimit;
	logic [PER_W-1:0] onCount;
	logic syncOk;
	logic hiccup;
	hbp_drive_t next_drive;

	// floors plus programmed extension
	assign leadCyc = DT_W'(LEAD_FLOOR_CYC) + {1'b0, dead[DT_W-1:0]};
	assign trailCyc =
		DT_W'(TRAIL_FLOOR_CYC) + {1'b0, dead[8+DT_W-1:8]};
	assign hiccup = stat.hiccup | restartTimerInput;

	// bus slave: one wait cycle, then answer
	// frozen like all other state while clkEn is low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ackPending <= 1'b0;
		end else if (clkEn) begin
			ackPending <= (avsRead | avsWrite) & ~ackPending;
		end
	end
	assign avsWaitRequest = (avsRead | avsWrite) & ~ackPending;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl <= CTRL_RESET;
			dead <= DEAD_RESET;
			period <= PER_RESET;
		end else if (clkEn && avsWrite && ackPending) begin
			for (int b = 0; b < 4; b++) begin
				if (avsByteEnable[b]) begin
					case (avsAddress)
					ADDR_CTRL: ctrl[b*8 +: 8] <= avsWriteData[b*8 +: 8];
					ADDR_DEAD: dead[b*8 +: 8] <= avsWriteData[b*8 +: 8];
					ADDR_PERIOD: begin
						if (b < 2) begin
							period[b*8 +: 8] <= avsWriteData[b*8 +: 8];
						end
					end
					default: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			avsReadData <= 32'h0000_0000;
		end else if (clkEn && avsRead && !ackPending) begin
			case (avsAddress)
			ADDR_CTRL: avsReadData <= ctrl;
			ADDR_DEAD: avsReadData <= dead;
			ADDR_STAT: avsReadData <= {19'h00000, stat, 1'b0, state,
				outEnable};
			ADDR_PERIOD: avsReadData <= {16'h0000, period};
			default: avsReadData <= 32'h0000_0000;
			endcase
		end
	end

	// sync pin: three stages, level moves when stages two and three agree
	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncPipe <= 3'b000;
			syncLevel <= 1'b0;
		end else if (clkEn) begin
			syncPipe <= {syncPipe[1:0], freqSetInput};
			if (syncPipe[1] == syncPipe[2]) begin
				syncLevel <= syncPipe[2];
			end
		end
	end

	// sync edge only counts when it comes earlier than the free period
	assign syncOk = ctrl[CTRL_SYNC_EN] && syncGap < period;
	assign syncEdge = syncLevel == 1'b0 && syncPipe[2] == 1'b1
		&& syncPipe[1] == 1'b1;

	// cycles since the last sync edge, saturating; a slow source never wins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncGap <= '1;
		end else if (clkEn) begin
			if (syncEdge) begin
				syncGap <= 16'h0001;
			end else if (syncGap != '1) begin
				syncGap <= syncGap + 16'h0001;
			end
		end
	end

	// period measure: free tick resets it; qualifying sync restarts period
	always_ff @(posedge clk) begin
		if (!resetn) begin
			oscCount <= '0;
		end else if (clkEn) begin
			if (tick) begin
				oscCount <= '0;
			end else begin
				oscCount <= oscCount + 16'h0001;
			end
		end
	end
	// measured tick spacing sizes the duty cap in every tick mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tickSpan <= '0;
		end else if (clkEn && tick) begin
			tickSpan <= oscCount + 16'h0001;
		end
	end

	// pure tick input when period is zero, else internal free timing
	assign tick = (syncEdge && syncOk)
		|| (period == '0 ? oscTick : oscCount + 16'h0001 >= period);

	// lead, pulse and trail must fit one tick spacing, so the pulse
	// never exceeds half the output cycle less the lead time
	assign spanEff = (tickSpan != '0) ? tickSpan : period;
	assign guardCyc = {7'h00, leadCyc} + {7'h00, trailCyc} + 16'h0001;
	always_comb begin
		if (spanEff == '0) begin
			halfLimit = 16'hffff; // no spacing known yet
		end else if (spanEff > guardCyc + 16'h0001) begin
			halfLimit = spanEff - guardCyc;
		end else begin
			halfLimit = 16'h0001;
		end
	end

	// enable sequencing
	always_ff @(posedge clk) begin
		if (!resetn) begin
			standby <= 1'b0;
		end else if (clkEn) begin
			if (stat.thermalTrip) begin
				standby <= 1'b1;
			end else if (stat.thermalRelease) begin
				standby <= 1'b0;
			end
		end
	end
	// bias regulator needs the start-level line sense
	always_ff @(posedge clk) begin
		if (!resetn) begin
			biasRegEnable <= 1'b0;
		end else if (clkEn) begin
			biasRegEnable <= stat.lineUvloStart && !standby;
		end
	end

	// reference waits for the bias supply to regulate
	always_ff @(posedge clk) begin
		if (!resetn) begin
			refEnable <= 1'b0;
		end else if (clkEn) begin
			refEnable <= stat.biasReady && stat.lineUvloStart
				&& !standby;
		end
	end

	// an external bias supply lets the start-up regulator rest
	always_ff @(posedge clk) begin
		if (!resetn) begin
			startupRegEnable <= 1'b0;
		end else if (clkEn) begin
			startupRegEnable <= stat.lineUvloStart && !standby
				&& !biasExternal;
		end
	end

	// drives wait for both regulators, line sense and the run bit
	always_ff @(posedge clk) begin
		if (!resetn) begin
			outEnable <= 1'b0;
		end else if (clkEn) begin
			outEnable <= stat.biasReady && stat.refReady && !stat.lineUvloLow
				&& !standby && ctrl[CTRL_RUN];
		end
	end

	// soft-start stays discharged until the drives may run again
	always_ff @(posedge clk) begin
		if (!resetn) begin
			softStartDischarge <= 1'b1;
		end else if (clkEn) begin
			softStartDischarge <= standby || !outEnable || hiccup;
		end
	end

	// pulse sequencer: lead, on, trail, wait for next tick
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			phaseHigh <= 1'b1;
			dtCount <= '0;
			onCount <= '0;
		end else if (clkEn) begin
			case (state)
			ST_IDLE: begin
				if (tick && outEnable) begin
					state <= ST_LEAD;
					dtCount <= '0;
				end
			end
			ST_LEAD: begin
				if (!outEnable) begin
					state <= ST_IDLE;
				end else if (dtCount + 9'h001 >= leadCyc) begin
					state <= ST_ON;
					onCount <= '0;
				end else begin
					dtCount <= dtCount + 9'h001;
				end
			end
			ST_ON: begin
				onCount <= onCount + 16'h0001;
				// comparator end flag or duty cap ends the pulse
				if (!outEnable || (pwmEnd && controlCurrent)
					|| onCount + 16'h0001 >= halfLimit
					|| tick) begin
					state <= ST_TRAIL;
					dtCount <= '0;
				end
			end
			ST_TRAIL: begin
				if (dtCount + 9'h001 >= trailCyc) begin
					state <= ST_WAIT;
					phaseHigh <= ~phaseHigh;
				end else begin
					dtCount <= dtCount + 9'h001;
				end
			end
			ST_WAIT: begin
				if (tick && outEnable) begin
					state <= ST_LEAD;
					dtCount <= '0;
				end else if (!outEnable) begin
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// output steering from sequencer state
	always_comb begin
		next_drive = '0;
		next_drive.rectifierDriveA = 1'b1;
		next_drive.rectifierDriveB = 1'b1;
		case (state)
		ST_LEAD: begin
			// opposite rectifier drops ahead of the pulse
			next_drive.rectifierDriveA = !phaseHigh;
			next_drive.rectifierDriveB = phaseHigh;
		end
		ST_ON: begin
			next_drive.highSideDrive = phaseHigh;
			next_drive.lowSideDrive = !phaseHigh;
			next_drive.rectifierDriveA = !phaseHigh;
			next_drive.rectifierDriveB = phaseHigh;
		end
		ST_TRAIL: begin
			next_drive.rectifierDriveA = !phaseHigh;
			next_drive.rectifierDriveB = phaseHigh;
		end
		default: ;
		endcase
		if (!outEnable) begin
			next_drive.highSideDrive = 1'b0;
			next_drive.lowSideDrive = 1'b0;
			next_drive.rectifierDriveA = 1'b0;
			next_drive.rectifierDriveB = 1'b0;
		end
		if (stat.softStartLow && outEnable && !hiccup) begin
			next_drive.rectifierDriveA = 1'b1;
			next_drive.rectifierDriveB = 1'b1;
		end
		if (stat.lineUvloLow || hiccup || standby) begin
			next_drive.rectifierDriveA = 1'b0;
			next_drive.rectifierDriveB = 1'b0;
		end
	end

	// registered so the pins never glitch between states
	always_ff @(posedge clk) begin
		if (!resetn) begin
			drive <= '0;
		end else if (clkEn) begin
			drive <= next_drive;
		end
	end
endmodule // hbp_steering

// ---- rtl/hbp_pkg.sv ----
// package for the half-bridge pwm steering block
package hbp_pkg;
	localparam int CLK_MHZ = 125;
	// least dead-time floors, in picoseconds
	localparam int LEAD_FLOOR_PS = 4600;
	localparam int TRAIL_FLOOR_PS = 10010;
	localparam int LEAD_FLOOR_CYC =
		(LEAD_FLOOR_PS * CLK_MHZ + 999999) / 1000000;
	localparam int TRAIL_FLOOR_CYC =
		(TRAIL_FLOOR_PS * CLK_MHZ + 999999) / 1000000;
	// least sync pulse width, ns
	localparam int SYNC_MIN_NS = 15;
	localparam int SYNC_MIN_CYC = (SYNC_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int DT_W = 8;
	localparam int PER_W = 16;
	localparam logic [PER_W-1:0] PER_RESET = 16'h0000;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DEAD = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_PERIOD = 8'h0c;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] DEAD_RESET = 32'h0000_0000;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_SYNC_EN = 1;
	localparam int STAT_ENABLED = 0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LEAD = 3'b001,
		ST_ON = 3'b010,
		ST_TRAIL = 3'b011,
		ST_WAIT = 3'b100
	} hbp_state_t;

	typedef struct packed {
		logic highSideDrive;
		logic lowSideDrive;
		logic rectifierDriveA;
		logic rectifierDriveB;
	} hbp_drive_t;

	typedef struct packed {
		logic lineUvloLow;
		logic lineUvloStart;
		logic biasReady;
		logic refReady;
		logic hiccup;
		logic softStartLow;
		logic thermalTrip;
		logic thermalRelease;
	} hbp_status_t;
endpackage

// ---- dv/hbp_steering_chk.sv ----
// assertion checker for the steering block outputs
`timescale 1ns/1ps
module hbp_steering_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic restartTimerInput,
	input wire hbp_pkg::hbp_status_t stat,
	input wire hbp_pkg::hbp_drive_t drive,
	input wire logic biasRegEnable,
	input wire logic refEnable,
	input wire logic softStartDischarge
);
	import hbp_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic hic;
	logic ok;
	assign hic = restartTimerInput | stat.hiccup;
	assign ok = stat.biasReady & stat.refReady & !stat.lineUvloLow;
	// forcing conditions are registered; let them settle first
	sequence s_quiet;
		(!hic && !stat.softStartLow && ok && !stat.thermalTrip)[*3];
	endsequence
	property p_excl;
		!(drive.highSideDrive && drive.lowSideDrive);
	endproperty
	property p_hiRect;
		s_quiet ##0 drive.highSideDrive |->
			drive.rectifierDriveB && !drive.rectifierDriveA;
	endproperty
	property p_loRect;
		s_quiet ##0 drive.lowSideDrive |->
			drive.rectifierDriveA && !drive.rectifierDriveB;
	endproperty
	property p_lead;
		s_quiet ##0 $rose(drive.highSideDrive) |->
			$past(!drive.rectifierDriveA);
	endproperty
	property p_hic;
		hic[*3] |-> !drive.rectifierDriveA && !drive.rectifierDriveB;
	endproperty
	property p_therm;
		stat.thermalTrip[*4] |-> !(|drive) && !biasRegEnable &&
			!refEnable && softStartDischarge;
	endproperty
	property p_ready;
		(!ok)[*4] |-> !(|drive);
	endproperty
	property p_bias;
		(!stat.lineUvloStart)[*3] |-> !biasRegEnable;
	endproperty
	a_excl: assert property (p_excl) else $error("both primaries on");
	a_hiRect: assert property (p_hiRect) else $error("high rect");
	a_loRect: assert property (p_loRect) else $error("low rect");
	a_lead: assert property (p_lead) else $error("no lead gap");
	a_hic: assert property (p_hic) else $error("rect not low");
	a_therm: assert property (p_therm) else $error("standby");
	a_ready: assert property (p_ready) else $error("drive unready");
	a_bias: assert property (p_bias) else $error("bias early");
endmodule // hbp_steering_chk

bind hbp_steering hbp_steering_chk u_chk (.clk, .resetn, .restartTimerInput,
	.stat, .drive, .biasRegEnable, .refEnable, .softStartDischarge);

// ---- dv/hbp_power_stage.sv ----
// power stage model: end-of-on-time comparator and sync source
`timescale 1ns/1ps
module hbp_power_stage (
	input wire logic clk,
	input wire hbp_pkg::hbp_drive_t drive,
	input wire logic [7:0] onLimit,
	input wire logic [7:0] syncPer,
	output logic pwmEnd,
	output logic freqSetInput
);
	import hbp_pkg::*;
	int onCnt = 0;
	int syncCnt = 0;
	always @(posedge clk) begin
		onCnt <= (drive.highSideDrive | drive.lowSideDrive) ? onCnt + 1 : 0;
		syncCnt <= (syncCnt + 1 >= syncPer) ? 0 : syncCnt + 1;
	end
	assign pwmEnd = onCnt >= onLimit;
	// 16 ns high, well under 60 percent of any period used
	assign freqSetInput = syncPer != 8'h00 && syncCnt < 2;
endmodule // hbp_power_stage

// ---- dv/test_hbp_steering.sv ----
// self-checking bench for the half-bridge steering block
`timescale 1ns/1ps
module test_hbp_steering;
	import hbp_pkg::*;
	logic clk = 0, resetn = 0, oscTick = 0, pwmEnd, freqSetInput;
	logic controlCurrent = 0, restartTimerInput = 0, biasExternal = 0;
	logic clkEn = 1;
	hbp_drive_t frozen;
	hbp_status_t stat = 8'h70;
	logic [7:0] avsAddress = 8'h00, onLimit = 8'h05, syncPer = 8'h00;
	logic avsRead = 0, avsWrite = 0, avsWaitRequest;
	logic [31:0] avsWriteData = 32'h0, avsReadData;
	logic biasRegEnable, refEnable, startupRegEnable, softStartDischarge;
	hbp_drive_t drive;
	logic [31:0] model [5];
	int failures = 0, nCompared = 0, cyc = 0, tickPer = 0, tcnt = 0;
	int hsR, lsR, last, maxW, leadSeen, trailSeen, lead, trail;
	always #4 clk = ~clk;
	hbp_steering DUT (.clk, .resetn, .clkEn, .oscTick, .freqSetInput,
		.pwmEnd, .controlCurrent, .restartTimerInput, .biasExternal, .stat,
		.avsAddress, .avsRead, .avsWrite, .avsWriteData,
		.avsByteEnable(4'hf), .avsReadData, .avsWaitRequest, .drive,
		.biasRegEnable, .refEnable, .startupRegEnable, .softStartDischarge);
	hbp_power_stage farSide (.clk, .drive, .onLimit, .syncPer, .pwmEnd,
		.freqSetInput);
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tcnt <= (tcnt + 1 >= tickPer) ? 0 : tcnt + 1;
		oscTick <= tickPer != 0 && tcnt == 0;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWriteData <= d;
		@(posedge clk);
		while (avsWaitRequest !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		q = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		check(n, 1);
	endtask
	task automatic wr(input int i, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, 8'(i * 4), d, q);
		// status is read-only and 0x10 is unmapped
		if (i != 2 && i != 4)
			model[i] = d & (i == 0 ? 32'h3 : 32'hffff);
	endtask
	task automatic rdall;
		logic [31:0] q;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0, q);
			check(q, model[i]);
		end
	endtask
	task automatic run(input int n);
		hbp_drive_t p;
		int lowA, w;
		lowA = 0;
		w = 0;
		hsR = 0;
		lsR = 0;
		maxW = 0;
		p = drive;
		repeat (n) begin
			@(posedge clk);
			if (drive.highSideDrive && !p.highSideDrive) begin
				hsR++;
				leadSeen = lowA;
				check(last == 1, 0);
				last = 1;
			end
			if (drive.lowSideDrive && !p.lowSideDrive) begin
				lsR++;
				check(last == 2, 0);
				last = 2;
			end
			if (drive.rectifierDriveA && !p.rectifierDriveA && last == 1)
				trailSeen = lowA;
			lowA = (drive.rectifierDriveA | drive.highSideDrive) ? 0 : lowA + 1;
			w = (drive.highSideDrive | drive.lowSideDrive) ? w + 1 : 0;
			maxW = w > maxW ? w : maxW;
			p = drive;
		end
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		void'($urandom(32'haf66ee6e));
		model = '{CTRL_RESET, DEAD_RESET, {19'h0, stat, 5'h00},
			{16'h0, PER_RESET}, 32'h0};
		onLimit = 8'($urandom_range(8, 3));
		lead = $urandom_range(3);
		trail = $urandom_range(3);
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rdall();
		wr(1, {16'h0, 8'(trail), 8'(lead)});
		wr(2, 32'hffffffff);
		wr(4, 32'h5a5a5a5a);
		wr(3, $urandom);
		rdall();
		wr(3, 32'h0);
		wr(0, 32'h1);
		tickPer <= 40;
		run(840);
		check(hsR inside {[10:11]} && lsR inside {[10:11]}, 1);
		check(leadSeen, lead + 1);
		check(trailSeen, trail + 2);
		check(maxW <= 39 - lead && maxW > 0, 1);
		clkEn <= 1'b0;
		@(posedge clk);
		frozen = drive;
		repeat (30) @(posedge clk);
		check(drive, frozen);
		clkEn <= 1'b1;
		controlCurrent <= 1'b1;
		run(400);
		check(maxW inside {[onLimit:onLimit + 3]}, 1);
		controlCurrent <= 1'b0;
		tickPer <= 0;
		wr(3, 32'h3c);
		wr(0, 32'h3);
		syncPer <= 8'h32;
		run(600);
		check(hsR + lsR inside {[11:13]}, 1);
		syncPer <= 8'h5a;
		run(600);
		check(hsR + lsR inside {[9:11]}, 1);
		syncPer <= 8'h00;
		wr(3, 32'h0);
		repeat (60) @(posedge clk);
		stat.softStartLow <= 1'b1;
		repeat (5) @(posedge clk);
		check({drive.rectifierDriveA, drive.rectifierDriveB}, 2'h3);
		restartTimerInput <= 1'b1;
		repeat (5) @(posedge clk);
		check({drive.rectifierDriveA, drive.rectifierDriveB}, 2'h0);
		restartTimerInput <= 1'b0;
		stat.softStartLow <= 1'b0;
		tickPer <= 40;
		stat.thermalTrip <= 1'b1;
		repeat (6) @(posedge clk);
		check({drive, biasRegEnable, refEnable, softStartDischarge},
			7'h01);
		stat.thermalTrip <= 1'b0;
		stat.lineUvloStart <= 1'b0;
		stat.lineUvloLow <= 1'b1;
		repeat (6) @(posedge clk);
		check({drive, biasRegEnable}, 5'h00);
		stat.lineUvloLow <= 1'b0;
		stat.lineUvloStart <= 1'b1;
		stat.thermalRelease <= 1'b1;
		repeat (4) @(posedge clk);
		check({biasRegEnable, startupRegEnable}, 2'h3);
		biasExternal <= 1'b1;
		repeat (4) @(posedge clk);
		check(startupRegEnable, 1'b0);
		summarize();
	end
endmodule // test_hbp_steering
